// file: src/ftrc_pkg.sv
// Package for the fault trigger recorder control block
package ftrc_pkg;
    localparam int FTRC_NTRIG = 8;
    localparam int FTRC_NDIN = 48;
    localparam int FTRC_QW = 16;
    // Percent settings in tenths of a percent
    localparam logic [11:0] FTRC_THR_MAX = 12'h7D0;
    localparam logic [11:0] FTRC_HYS_MAX = 12'h1F4;
    localparam logic [11:0] FTRC_HYS_RST = 12'h032;
    localparam logic [11:0] FTRC_THR_RST = 12'h3E8;
    localparam logic [13:0] FTRC_DUR_MAX = 14'h2710;
    localparam logic [13:0] FTRC_DUR_RST = 14'h0064;
    localparam logic [4:0] FTRC_CYC_MAX = 5'h14;
    localparam logic [4:0] FTRC_PRE_RST = 5'h04;
    localparam logic [4:0] FTRC_POST_RST = 5'h04;
    localparam logic [2:0] FTRC_WLOG_RST = 3'h6;
    localparam logic [3:0] FTRC_DLOG_NUM = 4'hD;
    localparam logic [31:0] FTRC_APB_CTRL = 32'h0000_0000;
    localparam logic [31:0] FTRC_APB_TREN = 32'h0000_0004;
    localparam logic [31:0] FTRC_APB_LOGC = 32'h0000_0008;
    localparam logic [31:0] FTRC_APB_DUR = 32'h0000_000C;
    localparam logic [31:0] FTRC_APB_STAT = 32'h0000_0010;
    localparam logic [31:0] FTRC_APB_LINK = 32'h0000_0014;
    localparam logic [31:0] FTRC_APB_LINKH = 32'h0000_0018;
    localparam logic [31:0] FTRC_APB_THR0 = 32'h0000_0040;
    localparam logic [31:0] FTRC_APB_HYS0 = 32'h0000_0080;
    // Trigger slots
    localparam int FTRC_T_UV1 = 0;
    localparam int FTRC_T_UV2 = 1;
    localparam int FTRC_T_OC = 2;
    localparam int FTRC_T_ZSV = 5;
    localparam int FTRC_T_VUNB = 6;
    localparam int FTRC_T_IUNB = 7;
    // Slots detecting a value below the threshold
    localparam logic [7:0] FTRC_UNDER = 8'h03;
    localparam logic [7:0] FTRC_TREN_RST = 8'h9F;
    localparam logic [7:0] FTRC_VOLT = 8'h63;
    localparam logic [1:0] FTRC_CTL_RST = 2'h3;
    localparam logic [3:0] FTRC_LOGC_RST = 4'h1;
endpackage

// file: src/ftrc_recorder.sv
// Fault trigger qualification and recorder control with APB setup
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// R1: Recording starts on internal detection or any of 48 linked inputs.
// R2: Global enable turns the whole recorder on or off.
// R3: Each analog trigger has an enable, set at reset except ZSV and VUNB, gating it out.
// R4: Threshold 0 to 200.0 percent of nominal, tenth percent steps.
// R5: Hysteresis 0 to 50.0 percent of threshold, default 5.0.
// R6: Waveform capture at start (default on) and at end (default off).
// R7: Waveform log file selectable 1 to 8, default 7.
// R8: Optional half-cycle RMS trace while fault persists, default off.
// R9: Trace stops post cycles after fault end or at cycle cap up to 10000, default 100.
// R10: Pre-event cycles 0 to 20, default 4.
// R11: Post-event cycles 0 to 20, default 4.
// R12: Fault data always goes to data log file 13.
// R13: Voltage and current faults except zero-sequence also to quality log unless routing cleared.
// R14: Voltage nominal is phase-neutral in wye modes, else phase-phase.
// R15: Current nominal is rated secondary current.
// R16: Overcurrent is ANDed with second undervoltage when that is enabled.
// R17: Zero-sequence and voltage unbalance triggers default disabled.
// R18: Current unbalance relates max deviation to rated current.
// R19: External linked inputs always trigger; only linked inputs count.
// R20: Flags: internal detection, external launch, and their OR.
// R21: Flags are levels following the fault condition.
// R22: Cross triggering relies on an external changeover relay.
// R23: Trigger clears only after passing threshold by the hysteresis.
module ftrc_recorder
    import ftrc_pkg::*;
#(
    parameter int NTRIG = FTRC_NTRIG,
    parameter int NDIN = FTRC_NDIN
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NTRIG*FTRC_QW-1:0] meas,
    input wire logic [FTRC_QW-1:0] v_phase_neutral,
    input wire logic [FTRC_QW-1:0] v_phase_phase,
    input wire logic [FTRC_QW-1:0] i_rated,
    input wire logic wye_four_wire_mode,
    input wire logic wye_three_element_mode,
    input wire logic wye_balanced_mode,
    input wire logic half_cycle_tick,
    input wire logic [NDIN-1:0] din,
    output logic fault_detected,
    output logic external_trigger,
    output logic fault_event,
    output logic wave_start,
    output logic wave_end,
    output logic [2:0] wave_log_file,
    output logic data_log_on,
    output logic [3:0] data_log_file,
    output logic [4:0] pre_cycles,
    output logic [4:0] post_cycles,
    output logic quality_log_on
);
    logic [1:0] ctrl;
    logic [NTRIG-1:0] tren;
    logic [3:0] logc;
    logic [2:0] wlog;
    logic [13:0] dur_max;
    logic [4:0] pre_n;
    logic [4:0] post_n;
    logic [63:0] link;
    logic [11:0] thr [NTRIG];
    logic [11:0] hys [NTRIG];
    logic [NDIN-1:0] din_s1;
    logic [NDIN-1:0] din_s2;
    logic [NTRIG-1:0] trip;
    logic [NTRIG-1:0] act;
    logic [13:0] trace_cnt;
    logic [4:0] post_cnt;
    logic int_det;
    logic ext_det;
    logic fe_q;
    logic half_ph;
    logic next_data_on;
    logic [31:0] rd;
    logic wr;

    assign wr = psel && penable && pwrite;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= FTRC_CTL_RST;
            tren <= FTRC_TREN_RST; // R3 R17
            logc <= FTRC_LOGC_RST; // R6 R8
            wlog <= FTRC_WLOG_RST; // R7
            dur_max <= FTRC_DUR_RST; // R9
            pre_n <= FTRC_PRE_RST; // R10
            post_n <= FTRC_POST_RST; // R11
            link <= 64'h0;
        end
        else if (wr)
        begin
            case (paddr)
                FTRC_APB_CTRL: ctrl <= pwdata[1:0];
                FTRC_APB_TREN: tren <= pwdata[NTRIG-1:0];
                FTRC_APB_LOGC:
                begin
                    logc <= pwdata[3:0];
                    wlog <= pwdata[6:4];
                    // Cycle counts are clipped to the legal range
                    pre_n <= (pwdata[12:8] > FTRC_CYC_MAX) ?
                        FTRC_CYC_MAX : pwdata[12:8]; // R10
                    post_n <= (pwdata[20:16] > FTRC_CYC_MAX) ?
                        FTRC_CYC_MAX : pwdata[20:16]; // R11
                end
                FTRC_APB_DUR: dur_max <= (pwdata[13:0] > FTRC_DUR_MAX) ?
                    FTRC_DUR_MAX : pwdata[13:0]; // R9
                FTRC_APB_LINK: link[31:0] <= pwdata;
                FTRC_APB_LINKH: link[63:32] <= pwdata;
                default: ;
            endcase
        end
    end

    // Per-trigger threshold, hysteresis and hysteretic comparator
    genvar g;
    generate
        for (g = 0; g < NTRIG; g++)
        begin : gen_trig
            logic [FTRC_QW-1:0] nom;
            logic [27:0] lvl_on;
            logic [27:0] lvl_off;
            logic [39:0] hys_t;
            logic [27:0] val;
            logic [11:0] wd;
            assign wd = pwdata[11:0];
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    thr[g] <= FTRC_THR_RST;
                    hys[g] <= FTRC_HYS_RST; // R5
                end
                else if (wr && paddr == FTRC_APB_THR0 + 32'(4 * g))
                    thr[g] <= (wd > FTRC_THR_MAX) ? FTRC_THR_MAX : wd; // R4
                else if (wr && paddr == FTRC_APB_HYS0 + 32'(4 * g))
                    hys[g] <= (wd > FTRC_HYS_MAX) ? FTRC_HYS_MAX : wd; // R5
            end
            // Wye modes use phase-neutral reference, currents the rating
            assign nom = !FTRC_VOLT[g] ? i_rated : // R15 R18
                (wye_four_wire_mode || wye_three_element_mode ||
                 wye_balanced_mode) ? v_phase_neutral : v_phase_phase; // R14
            // Scale: value*1000 compared with nom*thr (tenths percent)
            assign lvl_on = 28'(nom) * 28'(thr[g]);
            assign hys_t = 40'(lvl_on) * 40'(hys[g]);
            assign val = 28'(meas[g*FTRC_QW +: FTRC_QW]) * 28'd1000;
            assign lvl_off = FTRC_UNDER[g] ?
                lvl_on + 28'(hys_t / 40'd1000) :
                lvl_on - 28'(hys_t / 40'd1000);
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    trip[g] <= 1'b0;
                else if (!tren[g] || !ctrl[0])
                    trip[g] <= 1'b0; // R2 R3
                else if (FTRC_UNDER[g])
                    trip[g] <= trip[g] ? (val < lvl_off) : (val < lvl_on); // R23
                else
                    trip[g] <= trip[g] ? (val > lvl_off) : (val > lvl_on); // R23
            end
        end
    endgenerate

    // Overcurrent is only qualified by undervoltage when that is enabled
    always_comb
    begin
        act = trip;
        act[FTRC_T_OC] = trip[FTRC_T_OC] &&
            (!tren[FTRC_T_UV2] || trip[FTRC_T_UV2]); // R16
        act[FTRC_T_UV2] = trip[FTRC_T_UV2] && !tren[FTRC_T_OC];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            din_s1 <= '0;
            din_s2 <= '0;
        end
        else
        begin
            din_s1 <= din;
            din_s2 <= din_s1;
        end
    end

    assign int_det = |act; // R1
    // External path has no enable bit besides the global switch
    assign ext_det = |(din_s2 & link[NDIN-1:0]); // R19

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fault_detected <= 1'b0;
            external_trigger <= 1'b0;
            fault_event <= 1'b0;
            fe_q <= 1'b0;
        end
        else
        begin
            fault_detected <= int_det && ctrl[0]; // R20 R21
            external_trigger <= ext_det && ctrl[0]; // R1 R2 R19 R20
            fault_event <= (int_det || ext_det) && ctrl[0]; // R20 R21
            fe_q <= fault_event;
        end
    end

    // Limits are in full cycles, so counters step on every second tick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            half_ph <= 1'b0;
        else if (fault_event != fe_q)
            half_ph <= 1'b0;
        else if (half_cycle_tick)
            half_ph <= !half_ph;
    end

    // Trace stays on while the event lasts, up to the dur_max cycle cap, then post cycles
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trace_cnt <= '0;
            post_cnt <= '0;
        end
        else if (fault_event && !fe_q)
        begin
            trace_cnt <= '0;
            post_cnt <= post_n;
        end
        else if (half_cycle_tick && half_ph)
        begin
            if (fault_event && trace_cnt < dur_max)
                trace_cnt <= trace_cnt + 14'd1; // R9
            if (!fault_event && post_cnt != 5'd0)
                post_cnt <= post_cnt - 5'd1; // R11
        end
    end

    always_comb
    begin
        next_data_on = logc[1] && ((fault_event && trace_cnt < dur_max) ||
            (!fault_event && fe_q) ||
            (!fault_event && post_cnt != 5'd0 && data_log_on)); // R8 R9
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wave_start <= 1'b0;
            wave_end <= 1'b0;
            data_log_on <= 1'b0;
            quality_log_on <= 1'b0;
            wave_log_file <= FTRC_WLOG_RST;
            data_log_file <= FTRC_DLOG_NUM;
            pre_cycles <= FTRC_PRE_RST;
            post_cycles <= FTRC_POST_RST;
        end
        else
        begin
            wave_start <= logc[0] && fault_event && !fe_q; // R6
            wave_end <= logc[2] && !fault_event && fe_q; // R6
            data_log_on <= next_data_on; // R8
            quality_log_on <= ctrl[1] && fault_detected &&
                |(act & ~(NTRIG'(1) << FTRC_T_ZSV)); // R13
            wave_log_file <= wlog; // R7
            data_log_file <= FTRC_DLOG_NUM; // R12
            pre_cycles <= pre_n; // R10
            post_cycles <= post_n; // R11
        end
    end

    always_comb
    begin
        rd = 32'h0;
        case (paddr)
            FTRC_APB_CTRL: rd = {30'h0, ctrl};
            FTRC_APB_TREN: rd = 32'(tren);
            FTRC_APB_LOGC: rd = {11'h0, post_n, 3'h0, pre_n, 1'b0, wlog, logc};
            FTRC_APB_DUR: rd = {18'h0, dur_max};
            FTRC_APB_STAT: rd = {14'h0, trace_cnt, data_log_on, fault_event,
                external_trigger, fault_detected};
            FTRC_APB_LINK: rd = link[31:0];
            FTRC_APB_LINKH: rd = link[63:32];
            default:
            begin
                for (int k = 0; k < NTRIG; k++)
                begin
                    if (paddr == FTRC_APB_THR0 + 32'(4 * k))
                        rd = {20'h0, thr[k]};
                    if (paddr == FTRC_APB_HYS0 + 32'(4 * k))
                        rd = {20'h0, hys[k]};
                end
            end
        endcase
    end

    // Zero wait state slave; unmapped reads return zero without error
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            prdata <= rd;
            pready <= psel && !penable;
            pslverr <= 1'b0;
        end
    end

    a_flag_or: assert property ( // R20
        @(posedge pclk) disable iff (!presetn)
        fault_event == (fault_detected || external_trigger))
        else $error("combined flag not OR of flags");
    a_global_off: assert property ( // R2
        @(posedge pclk) disable iff (!presetn)
        !ctrl[0] |=> !fault_detected)
        else $error("flag with recorder disabled");
    a_ext_level: assert property ( // R19
        @(posedge pclk) disable iff (!presetn)
        ctrl[0] && ext_det |=> external_trigger)
        else $error("linked input did not trigger");
    a_int_level: assert property ( // R1 R21
        @(posedge pclk) disable iff (!presetn)
        ctrl[0] && int_det |=> fault_detected)
        else $error("internal detection did not flag");
    a_dlog_fixed: assert property ( // R12
        @(posedge pclk) disable iff (!presetn)
        data_log_file == FTRC_DLOG_NUM)
        else $error("data log file not 13");
    a_wave_start: assert property ( // R6
        @(posedge pclk) disable iff (!presetn)
        $rose(fault_event) && logc[0] && $past(logc[0]) |=> wave_start)
        else $error("no waveform at start");
    a_wave_end: assert property ( // R6
        @(posedge pclk) disable iff (!presetn)
        !logc[2] |=> !wave_end)
        else $error("waveform at end while disabled");
    a_trace_cap: assert property ( // R9
        @(posedge pclk) disable iff (!presetn)
        fault_event && $past(fault_event) && $stable(dur_max) |->
        trace_cnt <= dur_max)
        else $error("trace past cap");
    a_trace_off: assert property ( // R8
        @(posedge pclk) disable iff (!presetn)
        !logc[1] |=> !data_log_on)
        else $error("trace without enable");
    a_trig_gate: assert property ( // R3
        @(posedge pclk) disable iff (!presetn)
        (trip & ~$past(tren)) == '0)
        else $error("disabled trigger tripped");
    a_oc_qual: assert property ( // R16
        @(posedge pclk) disable iff (!presetn)
        tren[FTRC_T_UV2] && !trip[FTRC_T_UV2] |-> !act[FTRC_T_OC])
        else $error("overcurrent without undervoltage");
    a_pre_range: assert property ( // R10 R11
        @(posedge pclk) disable iff (!presetn)
        pre_n <= FTRC_CYC_MAX && post_n <= FTRC_CYC_MAX)
        else $error("cycle count out of range");
    c_fault: cover property (@(posedge pclk) $rose(fault_detected));
    c_ext: cover property (@(posedge pclk) $rose(external_trigger));
    c_end: cover property (@(posedge pclk) wave_end);
    c_oc_alone: cover property (@(posedge pclk) act[FTRC_T_OC]);
    c_trace_cap: cover property (@(posedge pclk) $fell(data_log_on));
endmodule // ftrc_recorder
`default_nettype wire

// file: tb/ftrc_line_model.sv
// Line quantity and digital input model for the fault recorder
`timescale 1ns/1ns
`default_nettype none
module ftrc_line_model
    import ftrc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [FTRC_NTRIG*FTRC_QW-1:0] meas_set,
    input wire logic [FTRC_NDIN-1:0] din_set,
    input wire logic [1:0] mode,
    input wire logic relay,
    output logic [FTRC_NTRIG*FTRC_QW-1:0] meas,
    output logic [FTRC_QW-1:0] v_phase_neutral,
    output logic [FTRC_QW-1:0] v_phase_phase,
    output logic [FTRC_QW-1:0] i_rated,
    output logic wye_four_wire_mode,
    output logic wye_three_element_mode,
    output logic wye_balanced_mode,
    output logic half_cycle_tick,
    output logic [FTRC_NDIN-1:0] din
);
    localparam int XBIT = 40;
    logic [2:0] tick_cnt;
    logic [FTRC_NDIN-1:0] din_nc;
    // Phase-phase kept well apart from phase-neutral to tell them apart
    assign v_phase_neutral = 16'h00C8;
    assign v_phase_phase = 16'h015A;
    assign i_rated = 16'h0064;
    assign wye_four_wire_mode = (mode == 2'h1);
    assign wye_three_element_mode = (mode == 2'h2);
    assign wye_balanced_mode = (mode == 2'h3);
    // A half cycle of 8 clocks keeps trace tests short
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt <= 3'h0;
            half_cycle_tick <= 1'b0;
        end
        else
        begin
            tick_cnt <= tick_cnt + 3'h1;
            half_cycle_tick <= (tick_cnt == 3'h7);
        end
    end
    // Own relay closes the shared trigger line on its normally open
    // contact; this unit's input sits behind the normally closed one
    always_comb
    begin
        din_nc = din_set;
        din_nc[XBIT] = (din_set[XBIT] || relay) && !relay;
    end
    always_ff @(posedge pclk)
    begin
        meas <= meas_set;
        din <= din_nc;
    end
endmodule // ftrc_line_model
`default_nettype wire

// file: tb/tb.sv
// Self-checking testbench for the fault recorder control
`timescale 1ns/1ns
`default_nettype none
module tb
    import ftrc_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [127:0] meas_set, meas;
    logic [47:0] din_set, din;
    logic [15:0] v_pn, v_pp, i_r;
    logic [1:0] mode;
    logic w4, w3, wb, tick, fd, ext, fev, ws, we, dlo, qlo;
    logic [2:0] wfile;
    logic [3:0] dfile;
    logic [4:0] pre, post;
    int n_mismatch, checked, cyc, ws_cnt, we_cnt;
    ftrc_line_model ftrc_line_model_i (.pclk(pclk), .presetn(presetn),
        .meas_set(meas_set), .din_set(din_set), .mode(mode), .relay(fd),
        .meas(meas),
        .v_phase_neutral(v_pn), .v_phase_phase(v_pp), .i_rated(i_r),
        .wye_four_wire_mode(w4), .wye_three_element_mode(w3),
        .wye_balanced_mode(wb), .half_cycle_tick(tick), .din(din));
    ftrc_recorder ftrc_recorder_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .meas(meas), .v_phase_neutral(v_pn),
        .v_phase_phase(v_pp), .i_rated(i_r), .wye_four_wire_mode(w4),
        .wye_three_element_mode(w3), .wye_balanced_mode(wb),
        .half_cycle_tick(tick), .din(din), .fault_detected(fd),
        .external_trigger(ext), .fault_event(fev), .wave_start(ws),
        .wave_end(we), .wave_log_file(wfile), .data_log_on(dlo),
        .data_log_file(dfile), .pre_cycles(pre), .post_cycles(post),
        .quality_log_on(qlo));
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc++;
        ws_cnt += (ws === 1'b1);
        we_cnt += (we === 1'b1);
        if (cyc == 20000)
        begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, s);
        checked++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("unexpected %s exp %h got %h", nm, e, s);
        end
    endtask
    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [31:0] a, d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic setm(input int g, input logic [15:0] v);
        @(posedge pclk);
        meas_set[16*g+:16] <= v;
    endtask
    // Flags lag the inputs by at most three edges plus the model's one
    task automatic settle();
        repeat (6) @(posedge pclk);
        #1;
    endtask
    task automatic t_reset();
        logic [31:0] a[8] = '{32'h0, 32'h4, 32'h8, 32'hC, 32'h40, 32'h80,
            32'h14, 32'h3C};
        logic [31:0] e[8] = '{32'h3, 32'h9F, 32'h0004_0461, 32'h64,
            32'h3E8, 32'h32, 32'h0, 32'h0};
        chk("wfile", 3'h6, wfile);
        chk("dfile", 4'hD, dfile);
        chk("pre", 5'h04, pre);
        chk("post", 5'h04, post);
        for (int k = 0; k < 8; k++)
        begin
            apb(1'b0, a[k], 32'h0);
            chk("reset reg", e[k], rd);
        end
    endtask
    task automatic t_overcurrent();
        setm(2, 16'h006E);
        settle();
        chk("oc qualified", 1'b0, fd);
        setm(1, 16'h0096);
        settle();
        chk("oc and uv2", 1'b1, fd);
        chk("event", 1'b1, fev);
        chk("ext", 1'b0, ext);
        chk("quality", 1'b1, qlo);
        chk("wave start", 32'd1, ws_cnt);
        setm(1, 16'h00DC);
        settle();
        chk("uv2 gone", 1'b0, fd);
        apb(1'b1, FTRC_APB_TREN, 32'h9D);
        settle();
        chk("oc alone", 1'b1, fd);
        setm(2, 16'h0061);
        settle();
        chk("in hysteresis", 1'b1, fd);
        setm(2, 16'h005F);
        settle();
        chk("cleared", 1'b0, fev);
    endtask
    task automatic t_global();
        apb(1'b1, FTRC_APB_CTRL, 32'h0);
        setm(2, 16'h006E);
        settle();
        chk("disabled", 1'b0, fev);
        apb(1'b1, FTRC_APB_CTRL, 32'h1);
        settle();
        chk("enabled", 1'b1, fd);
        chk("no routing", 1'b0, qlo);
        apb(1'b1, FTRC_APB_CTRL, 32'h3);
        setm(2, 16'h0000);
        settle();
    endtask
    task automatic t_external();
        @(posedge pclk);
        din_set[40] <= 1'b1;
        settle();
        chk("unlinked", 1'b0, ext);
        apb(1'b1, FTRC_APB_LINKH, 32'h100);
        settle();
        chk("linked", 1'b1, ext);
        chk("event", 1'b1, fev);
        chk("internal", 1'b0, fd);
        @(posedge pclk);
        din_set[40] <= 1'b0;
        settle();
        chk("ext level", 1'b0, fev);
        setm(2, 16'h006E);
        settle();
        chk("own detect", 1'b1, fd);
        chk("self trigger", 1'b0, ext);
        setm(2, 16'h0000);
        settle();
        apb(1'b1, FTRC_APB_LINKH, 32'h0);
    endtask
    task automatic t_wiring();
        apb(1'b1, FTRC_APB_TREN, 32'h01);
        setm(0, 16'h00FA);
        for (int m = 0; m < 4; m++)
        begin
            @(posedge pclk);
            mode <= m[1:0];
            settle();
            chk("nominal", (m == 0), fd);
        end
        setm(0, 16'h00DC);
        apb(1'b1, FTRC_APB_TREN, 32'h9D);
        settle();
        setm(7, 16'h006E);
        settle();
        chk("unbalance to rating", 1'b1, fd);
        setm(7, 16'h0000);
        settle();
    endtask
    task automatic t_trace();
        apb(1'b1, FTRC_APB_LOGC, 32'h0004_0467);
        apb(1'b1, FTRC_APB_DUR, 32'h3);
        setm(2, 16'h006E);
        settle();
        chk("trace on", 1'b1, dlo);
        repeat (80) @(posedge pclk);
        #1;
        chk("trace cap", 1'b0, dlo);
        chk("still fault", 1'b1, fd);
        apb(1'b0, FTRC_APB_STAT, 32'h0);
        chk("status", 32'h35, rd);
        setm(2, 16'h0000);
        settle();
        chk("wave end", 32'd1, we_cnt);
    endtask
    task automatic t_clip();
        logic [31:0] a[4] = '{32'h40, 32'h80, 32'h8, 32'hC};
        logic [31:0] e[4] = '{32'h7D0, 32'h1F4, 32'h0014_1471, 32'h2710};
        for (int k = 0; k < 4; k++)
        begin
            apb(1'b1, a[k], 32'h001F_FF71);
            apb(1'b0, a[k], 32'h0);
            chk("clip", e[k], rd);
        end
        #1;
        chk("wfile 8", 3'h7, wfile);
        chk("pre max", 5'h14, pre);
        chk("post max", 5'h14, post);
    endtask
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, din_set} = '0;
        meas_set = {16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h00DC,
            16'h00DC};
        mode = 2'h1;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        t_reset();
        t_overcurrent();
        t_global();
        t_external();
        t_wiring();
        t_trace();
        t_clip();
        summarize();
    end
endmodule // tb
`default_nettype wire
